//--- rtl/dic_defs.svh
// Offsets, field positions, reset values and timing counts of the input block
`ifndef DIC_DEFS_SVH
`define DIC_DEFS_SVH
// Register byte offsets on APB
`define DIC_OFS_GATE      8'h00
`define DIC_OFS_POLARITY  8'h04
`define DIC_OFS_OVR_SEL   8'h08
`define DIC_OFS_OVR_LEVEL 8'h0c
`define DIC_OFS_RAW       8'h10
`define DIC_OFS_THRESH    8'h14
`define DIC_OFS_SUMMARY   8'h18
`define DIC_OFS_OUTCMD    8'h1c
`define DIC_OFS_CONTROL   8'h20
// Field layout
`define DIC_NUM_IN        6
`define DIC_NUM_SPECIAL   3
`define DIC_NUM_THRESH    4
`define DIC_NUM_OUT       4
`define DIC_LEVEL_LSB     16
`define DIC_BIT_NEG_LIMIT 0
`define DIC_BIT_POS_LIMIT 1
`define DIC_BIT_HOME      2
`define DIC_BIT_BRAKE     0
`define DIC_BIT_ROUTE     0
// Reset values
`define DIC_RST_WORD      32'h0000_0000
// Timing: sample period and clock period in ns
`define DIC_SAMPLE_NS     1000000
`define DIC_CLK_NS        50
`define DIC_TICK_CYCLES   (`DIC_SAMPLE_NS / `DIC_CLK_NS)
`endif

//--- rtl/dic_pkg.sv
// Types shared by the input conditioning block
package dic_pkg;
  // Software configuration that shapes input processing
  typedef struct packed {
    logic [5:0] gate;
    logic [5:0] invert;
    logic [5:0] ovr_sel;
    logic [5:0] ovr_level;
    logic [3:0] thresh;
    logic       route;
  } dic_cfg_type;
  // Register selected by an APB address
  typedef enum logic [3:0] {
    DIC_SEL_GATE, DIC_SEL_POL, DIC_SEL_OSEL, DIC_SEL_OLEV, DIC_SEL_RAW,
    DIC_SEL_THR, DIC_SEL_SUM, DIC_SEL_OUT, DIC_SEL_CTL, DIC_SEL_NONE
  } dic_sel_type;
endpackage

//--- rtl/dic_top.sv
// Digital input conditioning with APB registers and output command word
`timescale 1ns/1ps
`include "dic_defs.svh"
`default_nettype none
module dic_top #(
  parameter int TICK_CYCLES = `DIC_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                     CLK_I,
  input  wire logic                     RST_B_I,
  // APB slave
  input  wire logic                     PSEL_I,
  input  wire logic                     PENABLE_I,
  input  wire logic                     PWRITE_I,
  input  wire logic [7:0]               PADDR_I,
  input  wire logic [31:0]              PWDATA_I,
  output logic      [31:0]              PRDATA_O,
  output logic                          PREADY_O,
  output logic                          PSLVERR_O,
  // Input pins
  input  wire logic [`DIC_NUM_IN-1:0]   IN_PIN_I,
  // Threshold select, four bits for the six inputs, 1 selects 24 V
  output logic      [`DIC_NUM_THRESH-1:0] THRESH_24V_O,
  // Output command levels and brake
  output logic      [`DIC_NUM_OUT-1:0]  OUT_LEVEL_O,
  output logic                          BRAKE_O
);
  import dic_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);
  localparam int NI = `DIC_NUM_IN;
  localparam int LS = `DIC_LEVEL_LSB;
  localparam int NS = `DIC_NUM_SPECIAL;

  // Reset release through two flops
  logic rst_s1_reg;
  logic rst_n;
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // Pin synchroniser; first stage feeds only the second
  logic [NI-1:0] in_s1_reg;
  logic [NI-1:0] in_s2_reg;
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_reg <= '0;
      in_s2_reg <= '0;
    end else begin
      in_s1_reg <= IN_PIN_I;
      in_s2_reg <= in_s1_reg;
    end
  end

  // Millisecond tick divider
  logic [TW-1:0] tick_cnt_reg;
  logic [TW-1:0] tick_cnt_next;
  logic          tick_reg;
  logic          tick_next;
  always_comb begin
    tick_next     = 1'b0;
    tick_cnt_next = tick_cnt_reg + 1'b1;
    if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_next = '0;
      tick_next     = 1'b1;
    end
  end
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  // Sampling: a new level is taken only when two ticks agree,
  // so a pulse shorter than one period never reaches the summary
  logic [NI-1:0] samp_reg;
  logic [NI-1:0] samp_next;
  logic [NI-1:0] stable_reg;
  logic [NI-1:0] stable_next;
  logic          upd_reg;
  always_comb begin
    samp_next   = samp_reg;
    stable_next = stable_reg;
    if (tick_reg) begin
      samp_next = in_s2_reg;
      for (int i = 0; i < NI; i++) begin
        if (in_s2_reg[i] == samp_reg[i]) begin
          stable_next[i] = in_s2_reg[i];
        end
      end
    end
  end
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      samp_reg   <= '0;
      stable_reg <= '0;
      upd_reg    <= 1'b0;
    end else begin
      samp_reg   <= samp_next;
      stable_reg <= stable_next;
      upd_reg    <= tick_reg;
    end
  end

  // Configuration and command registers
  dic_cfg_type cfg_reg;
  dic_cfg_type cfg_next;
  logic [31:0] outcmd_reg;
  logic [31:0] outcmd_next;
  logic [31:0] summary_reg;
  logic [31:0] summary_next;

  // Per-input processing chain
  logic [NI-1:0] forced;
  logic [NI-1:0] level;
  logic [NS-1:0] special;
  always_comb begin
    forced  = '0;
    level   = '0;
    special = '0;
    for (int i = 0; i < NI; i++) begin
      // Override first, then polarity, per own bit only
      forced[i] = cfg_reg.ovr_sel[i] ? cfg_reg.ovr_level[i]
                                     : stable_reg[i];
      level[i]  = forced[i] ^ cfg_reg.invert[i];
    end
    for (int i = 0; i < NS; i++) begin
      special[i] = level[i] & cfg_reg.gate[i];
    end
    if (cfg_reg.route) begin
      // Routing table lives elsewhere; words above are ignored here
      level   = stable_reg;
      special = stable_reg[NS-1:0];
    end
  end

  // Summary refresh, all bits at once after each sample
  always_comb begin
    summary_next = summary_reg;
    if (upd_reg) begin
      summary_next          = '0;
      summary_next[NS-1:0]  = special;
      summary_next[LS+:NI]  = level;
    end
  end
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      summary_reg <= `DIC_RST_WORD;
    end else begin
      summary_reg <= summary_next;
    end
  end

  // APB decode
  dic_sel_type sel;
  always_comb begin
    unique case (PADDR_I)
      `DIC_OFS_GATE:      sel = DIC_SEL_GATE;
      `DIC_OFS_POLARITY:  sel = DIC_SEL_POL;
      `DIC_OFS_OVR_SEL:   sel = DIC_SEL_OSEL;
      `DIC_OFS_OVR_LEVEL: sel = DIC_SEL_OLEV;
      `DIC_OFS_RAW:       sel = DIC_SEL_RAW;
      `DIC_OFS_THRESH:    sel = DIC_SEL_THR;
      `DIC_OFS_SUMMARY:   sel = DIC_SEL_SUM;
      `DIC_OFS_OUTCMD:    sel = DIC_SEL_OUT;
      `DIC_OFS_CONTROL:   sel = DIC_SEL_CTL;
      default:            sel = DIC_SEL_NONE;
    endcase
  end

  // APB slave: one wait-free access phase, ready from a flop
  logic        setup;
  logic        wr_acc;
  logic [31:0] rdata;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        pslverr_next;
  assign setup  = PSEL_I & ~PENABLE_I;
  assign wr_acc = PSEL_I & PENABLE_I & pready_reg & PWRITE_I;
  always_comb begin
    rdata = '0;
    unique case (sel)
      DIC_SEL_GATE: rdata[NI-1:0] = cfg_reg.gate;
      DIC_SEL_POL:  rdata[NI-1:0] = cfg_reg.invert;
      DIC_SEL_OSEL: rdata[NI-1:0] = cfg_reg.ovr_sel;
      DIC_SEL_OLEV: rdata[NI-1:0] = cfg_reg.ovr_level;
      DIC_SEL_RAW:  rdata[NI-1:0] = stable_reg;
      DIC_SEL_THR:  rdata[`DIC_NUM_THRESH-1:0] = cfg_reg.thresh;
      DIC_SEL_SUM:  rdata = summary_reg;
      DIC_SEL_OUT:  rdata = outcmd_reg;
      DIC_SEL_CTL:  rdata[`DIC_BIT_ROUTE] = cfg_reg.route;
      DIC_SEL_NONE: rdata = '0;
    endcase
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (setup) begin
      prdata_next  = PWRITE_I ? '0 : rdata;
      pslverr_next = (sel == DIC_SEL_NONE);
    end
  end

  // Register writes, only on the completing access edge
  always_comb begin
    cfg_next    = cfg_reg;
    outcmd_next = outcmd_reg;
    if (wr_acc) begin
      unique case (sel)
        DIC_SEL_GATE: cfg_next.gate      = PWDATA_I[NI-1:0];
        DIC_SEL_POL:  cfg_next.invert    = PWDATA_I[NI-1:0];
        DIC_SEL_OSEL: cfg_next.ovr_sel   = PWDATA_I[NI-1:0];
        DIC_SEL_OLEV: cfg_next.ovr_level = PWDATA_I[NI-1:0];
        DIC_SEL_THR:  cfg_next.thresh    = PWDATA_I[`DIC_NUM_THRESH-1:0];
        DIC_SEL_OUT:  outcmd_next        = PWDATA_I;
        DIC_SEL_CTL:  cfg_next.route     = PWDATA_I[`DIC_BIT_ROUTE];
        DIC_SEL_RAW,
        DIC_SEL_SUM,
        DIC_SEL_NONE: cfg_next = cfg_reg;
      endcase
    end
  end
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg     <= '0;
      outcmd_reg  <= `DIC_RST_WORD;
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      cfg_reg     <= cfg_next;
      outcmd_reg  <= outcmd_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= setup;
      pslverr_reg <= pslverr_next;
    end
  end

  // Pin-facing outputs, each from a flop
  logic [`DIC_NUM_OUT-1:0]    out_lvl_reg;
  logic [`DIC_NUM_THRESH-1:0] thr_reg;
  logic                       brake_reg;
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      out_lvl_reg <= '0;
      thr_reg     <= '0;
      brake_reg   <= 1'b0;
    end else begin
      out_lvl_reg <= outcmd_reg[LS+:`DIC_NUM_OUT];
      thr_reg     <= cfg_reg.thresh;
      brake_reg   <= outcmd_reg[`DIC_BIT_BRAKE];
    end
  end

  assign PRDATA_O     = prdata_reg;
  assign PREADY_O     = pready_reg;
  assign PSLVERR_O    = pslverr_reg;
  assign THRESH_24V_O = thr_reg;
  assign OUT_LEVEL_O  = out_lvl_reg;
  assign BRAKE_O      = brake_reg;

  // Checks on the processing chain and bus timing
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  sequence s_plain_update;
    upd_reg && !cfg_reg.route;
  endsequence

  sequence s_sample_done;
    tick_reg ##1 upd_reg;
  endsequence

  a_tick_spacing: assert property (
    tick_reg |-> tick_cnt_reg == '0
  ) else $error("tick not aligned with divider wrap");

  a_filter_agree: assert property (
    $changed(stable_reg) |-> $past(tick_reg) && stable_reg == $past(samp_reg)
  ) else $error("input accepted without two agreeing samples");

  a_summary_after: assert property (
    s_sample_done |=> summary_reg[LS+:NI] == $past(level)
  ) else $error("levels not refreshed after sample");

  a_invert_level: assert property (
    (s_plain_update and !cfg_reg.ovr_sel[0])
      |=> summary_reg[LS] == $past(stable_reg[0] ^ cfg_reg.invert[0])
  ) else $error("input one level wrong polarity");

  a_override_wins: assert property (
    (s_plain_update and cfg_reg.ovr_sel[1])
      |=> summary_reg[LS+1] == $past(cfg_reg.ovr_level[1] ^ cfg_reg.invert[1])
  ) else $error("override level not applied");

  a_gate_off: assert property (
    (s_plain_update and !cfg_reg.gate[`DIC_BIT_HOME]) |=> !summary_reg[`DIC_BIT_HOME]
  ) else $error("gated special bit set");

  a_special_match: assert property (
    (s_plain_update and cfg_reg.gate[`DIC_BIT_NEG_LIMIT])
      |=> summary_reg[`DIC_BIT_NEG_LIMIT] == summary_reg[LS]
  ) else $error("negative limit differs from input one level");

  a_unused_zero: assert property (
    summary_reg[15:NS] == '0 && summary_reg[31:LS+NI] == '0
  ) else $error("unused summary bits set");

  a_route_raw: assert property (
    upd_reg && cfg_reg.route |=> summary_reg[LS+:NI] == $past(stable_reg)
  ) else $error("configuration used while routing");

  a_output_bit: assert property (
    $changed(outcmd_reg[LS+1]) |=> OUT_LEVEL_O[1] == $past(outcmd_reg[LS+1])
  ) else $error("output two not from bit seventeen");

  a_thresh_out: assert property (
    ##1 THRESH_24V_O == $past(cfg_reg.thresh)
  ) else $error("threshold select not forwarded");

  a_apb_ready: assert property (
    setup |=> PREADY_O ##1 !PREADY_O
  ) else $error("ready not one cycle after setup");

  // Error response must ride on the same access cycle as ready
  a_slverr_unmapped: assert property (
    setup && sel == DIC_SEL_NONE |=> PSLVERR_O && PREADY_O
  ) else $error("unmapped access without error response");

  a_summary_hold: assert property (
    !upd_reg |=> $stable(summary_reg)
  ) else $error("summary changed outside an update");

  a_level_ungated: assert property (
    (s_plain_update and !cfg_reg.ovr_sel[2])
      |=> summary_reg[LS+2] == $past(stable_reg[2] ^ cfg_reg.invert[2])
  ) else $error("home input level depends on gate");

  a_route_special: assert property (
    upd_reg && cfg_reg.route |=> summary_reg[NS-1:0] == $past(stable_reg[NS-1:0])
  ) else $error("special bits not raw while routing");

  a_gate_write: assert property (
    wr_acc && sel == DIC_SEL_GATE |=> cfg_reg.gate == $past(PWDATA_I[NI-1:0])
  ) else $error("gate write did not land");

endmodule
`default_nettype wire

//--- tb/dic_source_model.sv
// Behavioural switch and signal sources on the six input pins
`timescale 1ns/1ps
`default_nettype none
module dic_source_model (
  // Clock that times pin changes
  input  wire logic       clk_i,
  // Levels driven onto the input pins, bit i is input i+1
  output var  logic [5:0] pins_o
);
  initial pins_o = 6'h00;

  // Steady switch level, changed just after an edge
  task automatic set_level(input logic [5:0] v);
    @(posedge clk_i);
    pins_o <= v;
  endtask

  // Contact bounce on one input; len must stay below one sample period to be rejected
  task automatic bounce(input int idx, input int len);
    @(posedge clk_i);
    pins_o[idx] <= ~pins_o[idx];
    repeat (len) @(posedge clk_i);
    pins_o[idx] <= ~pins_o[idx];
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the input conditioning block
`timescale 1ns/1ps
`include "dic_defs.svh"
`default_nettype none
module tb_top;
  // Short sample period keeps the run small
  localparam int TICK = 8;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  pins;
  logic [3:0]  thresh;
  logic [3:0]  out_level;
  logic        brake;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cycles = 0;

  dic_top #(.TICK_CYCLES(TICK)) i_dic_top (
    .CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .IN_PIN_I(pins),
    .THRESH_24V_O(thresh), .OUT_LEVEL_O(out_level), .BRAKE_O(brake)
  );
  dic_source_model i_dic_source_model (.clk_i(clk), .pins_o(pins));

  // Clock, 50 ns period
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard; the whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'h1;
    // Only the bench timeout ends a wait that never sees ready
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic cfg(input logic [5:0] g, p, os, ol);
    apb(1'h1, `DIC_OFS_GATE, {26'h0, g});
    apb(1'h1, `DIC_OFS_POLARITY, {26'h0, p});
    apb(1'h1, `DIC_OFS_OVR_SEL, {26'h0, os});
    apb(1'h1, `DIC_OFS_OVR_LEVEL, {26'h0, ol});
  endtask

  // Reference summary: override, then invert, then gate; routing passes raw through
  function automatic logic [31:0] exp_sum(input logic [5:0] raw, g, p, os, ol,
                                          input logic rt);
    logic [5:0] lv;
    logic [2:0] sp;
    lv = ((os & ol) | (~os & raw)) ^ p;
    sp = lv[2:0] & g[2:0];
    if (rt) begin
      lv = raw;
      sp = raw[2:0];
    end
    return {10'h000, lv, 13'h0000, sp};
  endfunction

  task automatic t_reset;
    logic [7:0] ofs [9];
    ofs = '{`DIC_OFS_GATE, `DIC_OFS_POLARITY, `DIC_OFS_OVR_SEL, `DIC_OFS_OVR_LEVEL,
            `DIC_OFS_RAW, `DIC_OFS_THRESH, `DIC_OFS_SUMMARY, `DIC_OFS_OUTCMD,
            `DIC_OFS_CONTROL};
    foreach (ofs[i]) begin
      apb(1'h0, ofs[i], 32'h0);
      check("reset value", rd, 32'h0);
    end
    apb(1'h0, 8'h24, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    check("outputs at reset", {23'h0, thresh, out_level, brake}, 32'h0);
  endtask

  task automatic t_regs;
    apb(1'h1, `DIC_OFS_THRESH, 32'hffff_ffff);
    apb(1'h0, `DIC_OFS_THRESH, 32'h0);
    check("threshold word", rd, 32'h0000_000f);
    check("threshold pins", {28'h0, thresh}, 32'h0000_000f);
    apb(1'h1, `DIC_OFS_THRESH, 32'h0000_0025);
    apb(1'h0, `DIC_OFS_GATE, 32'h0);
    check("threshold select", {28'h0, thresh}, 32'h0000_0005);
    apb(1'h1, `DIC_OFS_GATE, 32'hffff_ffff);
    apb(1'h0, `DIC_OFS_GATE, 32'h0);
    check("gate word", rd, 32'h0000_003f);
    apb(1'h1, `DIC_OFS_RAW, 32'hffff_ffff);
    apb(1'h0, `DIC_OFS_RAW, 32'h0);
    check("raw read only", rd, 32'h0);
    cfg(6'h00, 6'h00, 6'h00, 6'h00);
  endtask

  task automatic t_out;
    apb(1'h1, `DIC_OFS_OUTCMD, 32'h0003_0001);
    apb(1'h0, `DIC_OFS_OUTCMD, 32'h0);
    check("output word", rd, 32'h0003_0001);
    check("output pins", {27'h0, out_level, brake}, 32'h0000_0007);
    apb(1'h1, `DIC_OFS_OUTCMD, 32'h000a_0000);
    apb(1'h0, `DIC_OFS_OUTCMD, 32'h0);
    check("output pins", {27'h0, out_level, brake}, 32'h0000_0014);
  endtask

  // Columns: pins, gate, polarity, override select, override level
  task automatic t_proc;
    logic [5:0] tv [6][5];
    tv = '{'{6'h15, 6'h00, 6'h00, 6'h00, 6'h00}, '{6'h15, 6'h07, 6'h00, 6'h00, 6'h00},
           '{6'h15, 6'h07, 6'h03, 6'h00, 6'h00}, '{6'h00, 6'h07, 6'h00, 6'h21, 6'h01},
           '{6'h3f, 6'h07, 6'h02, 6'h3f, 6'h00}, '{6'h07, 6'h03, 6'h00, 6'h00, 6'h00}};
    for (int i = 0; i < 6; i++) begin
      cfg(tv[i][1], tv[i][2], tv[i][3], tv[i][4]);
      i_dic_source_model.set_level(tv[i][0]);
      repeat (5 * TICK) @(posedge clk);
      apb(1'h0, `DIC_OFS_SUMMARY, 32'h0);
      check("summary", rd, exp_sum(tv[i][0], tv[i][1], tv[i][2], tv[i][3], tv[i][4], 1'h0));
      apb(1'h0, `DIC_OFS_RAW, 32'h0);
      check("raw", rd, {26'h0, tv[i][0]});
    end
  endtask

  task automatic t_glitch;
    cfg(6'h00, 6'h00, 6'h00, 6'h00);
    i_dic_source_model.set_level(6'h00);
    repeat (5 * TICK) @(posedge clk);
    i_dic_source_model.bounce(1, TICK - 2);
    repeat (5 * TICK) @(posedge clk);
    apb(1'h0, `DIC_OFS_SUMMARY, 32'h0);
    check("bounce rejected", rd, 32'h0);
    i_dic_source_model.set_level(6'h02);
    repeat (5 * TICK) @(posedge clk);
    apb(1'h0, `DIC_OFS_SUMMARY, 32'h0);
    check("level accepted", rd, 32'h0002_0000);
  endtask

  task automatic t_route;
    cfg(6'h00, 6'h3f, 6'h3f, 6'h00);
    apb(1'h1, `DIC_OFS_CONTROL, 32'h0000_0001);
    i_dic_source_model.set_level(6'h2a);
    repeat (5 * TICK) @(posedge clk);
    apb(1'h0, `DIC_OFS_SUMMARY, 32'h0);
    check("routed summary", rd, exp_sum(6'h2a, 6'h0, 6'h0, 6'h0, 6'h0, 1'h1));
    apb(1'h1, `DIC_OFS_CONTROL, 32'h0);
    repeat (5 * TICK) @(posedge clk);
    apb(1'h0, `DIC_OFS_SUMMARY, 32'h0);
    check("normal again", rd, exp_sum(6'h2a, 6'h0, 6'h3f, 6'h3f, 6'h0, 1'h0));
  endtask

  // Main sequence; first transfer three edges after reset release
  initial begin
    rst_b   = 1'h0;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    t_reset();
    t_regs();
    t_out();
    t_proc();
    t_glitch();
    t_route();
    end_sim();
  end
endmodule
`default_nettype wire
